// File: hw/spo_top.sv
/*
 * Serial-in parallel-out latch: shift chain on the controller's shift clock,
 * a FIFO carrying each shifted snapshot into the core domain, and the
 * holding latch with three-state parallel outputs on the core clock.
 * Assumes the shift clock is slower than a third of the core clock, and
 * that latch clock, reset pin and output enable pin are asynchronous pins.
 */
// Summary of operation
// R01 - Each rising shift clock edge loads serial input and moves stages toward cascade.
// R02 - Without a rising shift clock edge the shift stages stay unchanged.
// R03 - Rising latch clock copies all stages into the holding latch.
// R04 - Without a rising latch clock edge the holding latch keeps its contents.
// R05 - Enable low drives latch onto outputs; high floats them, nothing else changes.
// R06 - Reset pin low clears stages and cascade output at once, clock independent.
// R07 - Reset pin never touches the holding latch or the driven outputs.
// R08 - Shift chain and latch are eight bits; stage A in, stage H out.
`timescale 1ns/1ps

module spo_fifo #(
   parameter int unsigned W     = 8,
   parameter int unsigned DEPTH = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         clr,
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
         $error("spo_fifo: DEPTH must be a power of two, at least 2");
   end

   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wr_ptr;
   logic [AW:0]  rd_ptr;

   wire do_push = in_valid & in_ready;
   wire do_pop  = out_valid & out_ready;

   assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else if (clr) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_push)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_pop)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (do_push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule

module spo_top #(
   parameter int unsigned WIDTH      = spo_pkg::SPO_WIDTH,
   parameter int unsigned FIFO_DEPTH = spo_pkg::SPO_FIFO_DEPTH
) (
   input  wire logic             core_clk,
   input  wire logic             nrst,
   input  wire logic             shift_clk,
   input  wire logic             shift_rst_n,
   input  wire logic             serial_in,
   input  wire logic             latch_clk,
   input  wire logic             out_enable_n,
   output      logic             cascade_serial_out,
   output      spo_pkg::spo_par_t parallel_outputs
);
   import spo_pkg::*;

   initial begin
      if (WIDTH != SPO_WIDTH)
         $error("spo_top: WIDTH must equal the carrier width");
   end

   // Link domain: shift chain on the controller's shift clock
   logic [WIDTH-1:0] shift_stages;
   logic [WIDTH-1:0] shift_snap;
   logic             shift_tog;

   wire [WIDTH-1:0] next_stages = {shift_stages[WIDTH-2:0], serial_in};   // see R08

   // Reset pin acts here asynchronously, nowhere else in this domain
   always_ff @(posedge shift_clk or negedge shift_rst_n) begin
      if (!shift_rst_n) begin
         shift_stages       <= SPO_STAGES_RST;   // see R06
         shift_snap         <= SPO_STAGES_RST;
         shift_tog          <= 1'b0;
         cascade_serial_out <= 1'b0;             // see R06
      end else begin
         shift_stages       <= next_stages;      // see R01, R02
         shift_snap         <= next_stages;
         shift_tog          <= ~shift_tog;
         cascade_serial_out <= next_stages[WIDTH-1];   // see R01
      end
   end

   // Core domain synchronisers
   logic tog_s1, tog_s2, tog_seen;
   logic rst_s1, rst_s2;
   logic lat_s1, lat_s2, lat_s3;
   logic oe_s1, oe_s2;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tog_s1 <= 1'b0;
         tog_s2 <= 1'b0;
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
         lat_s1 <= 1'b0;
         lat_s2 <= 1'b0;
         lat_s3 <= 1'b0;
         oe_s1  <= 1'b1;
         oe_s2  <= 1'b1;
      end else begin
         tog_s1 <= shift_tog;
         tog_s2 <= tog_s1;
         rst_s1 <= shift_rst_n;
         rst_s2 <= rst_s1;
         lat_s1 <= latch_clk;
         lat_s2 <= lat_s1;
         lat_s3 <= lat_s2;
         oe_s1  <= out_enable_n;
         oe_s2  <= oe_s1;
      end
   end

   // Snapshot is stable for a whole shift period after its toggle lands.
   // Limitation: a full FIFO for longer than that period would lose words.
   wire              pending   = (tog_s2 != tog_seen) & rst_s2;
   wire              shift_clr = ~rst_s2;
   logic             push_ready;
   logic             pop_valid;
   logic [WIDTH-1:0] pop_data;
   spo_state_t       state;
   spo_state_t       next_state;
   logic [2:0]       settle;
   logic [WIDTH-1:0] mirror;

   wire pop_ready  = (state != SPO_COPY);   // drain stalls during the copy
   wire latch_rise = lat_s2 & ~lat_s3;
   wire flush_done = ~pop_valid & ~pending & (settle == SPO_SETTLE_RST);

   spo_fifo #(
      .W     (WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (core_clk),
      .rst_n     (nrst),
      .clr       (shift_clr),
      .in_valid  (pending),
      .in_ready  (push_ready),
      .in_data   (shift_snap),
      .out_valid (pop_valid),
      .out_ready (pop_ready),
      .out_data  (pop_data)
   );

   always_comb begin
      case (state)
         SPO_IDLE:  next_state = latch_rise ? SPO_FLUSH : SPO_IDLE;   // see R03, R04
         SPO_FLUSH: next_state = flush_done ? SPO_COPY : SPO_FLUSH;
         SPO_COPY:  next_state = SPO_IDLE;
         default:   next_state = SPO_IDLE;
      endcase
   end

   wire [2:0] next_settle = (pending | pop_valid) ? 3'(SPO_SETTLE_CYC - 1) :
                            (settle != SPO_SETTLE_RST) ? settle - 3'h1 : settle;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state    <= SPO_IDLE;
         settle   <= SPO_SETTLE_RST;
         tog_seen <= 1'b0;
      end else begin
         state    <= next_state;
         settle   <= next_settle;
         tog_seen <= shift_clr ? 1'b0 : ((pending & push_ready) ? tog_s2 : tog_seen);
      end
   end

   // Core copy of the shift chain; cleared with it by the reset pin
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst)
         mirror <= SPO_STAGES_RST;
      else if (shift_clr)
         mirror <= SPO_STAGES_RST;   // see R06
      else if (pop_valid & pop_ready)
         mirror <= pop_data;
   end

   // Holding latch is the output register; only a latch edge changes it
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         parallel_outputs.data <= SPO_LATCH_RST;
         parallel_outputs.oe   <= SPO_OE_RST;
      end else begin
         if (state == SPO_COPY)
            parallel_outputs.data <= mirror;             // see R03, R07
         parallel_outputs.oe <= {WIDTH{~oe_s2}};         // see R05
      end
   end
endmodule

// File: hw/spo_pkg.sv
/*
 * Shared constants and carrier types for the serial-in parallel-out latch.
 * Assumes a core clock domain and a separate shift clock from the controller.
 */
package spo_pkg;

   localparam int unsigned SPO_WIDTH      = 8;
   localparam int unsigned SPO_FIFO_DEPTH = 8;
   // Core cycles with no pending shift before a latch copy is trusted
   localparam int unsigned SPO_SETTLE_CYC = 4;

   localparam logic [SPO_WIDTH-1:0] SPO_STAGES_RST = 8'h00;
   localparam logic [SPO_WIDTH-1:0] SPO_LATCH_RST  = 8'h00;
   localparam logic [SPO_WIDTH-1:0] SPO_OE_RST     = 8'h00;
   localparam logic [2:0]           SPO_SETTLE_RST = 3'h0;

   typedef struct packed {
      logic [SPO_WIDTH-1:0] data;
      logic [SPO_WIDTH-1:0] oe;
   } spo_par_t;

   // Gray codes along idle -> flush -> copy
   typedef enum logic [1:0] {
      SPO_IDLE  = 2'b00,
      SPO_FLUSH = 2'b01,
      SPO_COPY  = 2'b11
   } spo_state_t;

endpackage

// File: verification/spo_ctrl_model.sv
/* Controller model driving serial data, shift clock and latch pin.
   Assumes the bench waits out the latch settling time after each call. */
`timescale 1ns/1ps
module spo_ctrl_model (
   output logic shift_clk,
   output logic serial_in,
   output logic latch_clk
);
   initial begin
      shift_clk = 1'b0;
      serial_in = 1'b0;
      latch_clk = 1'b0;
   end
   // Bit 7 goes first so it ends in stage H; clock stands still between bytes
   task automatic send_byte(input logic [7:0] b);
      #3;
      for (int i = 7; i >= 0; i--) begin
         serial_in = b[i];
         #16 shift_clk = 1'b1;
         #16 shift_clk = 1'b0;
      end
      serial_in = ~b[0];
   endtask
   task automatic pulse_latch;
      #5 latch_clk = 1'b1;
      #40 latch_clk = 1'b0;
   endtask
endmodule

// File: verification/spo_checker.sv
/* Port checker for the shift chain, holding latch and output enable.
   Assumes bench keeps 20 core cycles between shifts and latch edges. */
`timescale 1ns/1ps
module spo_checker #(
   parameter int unsigned WIDTH      = 8,
   parameter int unsigned FIFO_DEPTH = 8
) (
   input wire logic              core_clk,
   input wire logic              nrst,
   input wire logic              shift_clk,
   input wire logic              shift_rst_n,
   input wire logic              serial_in,
   input wire logic              latch_clk,
   input wire logic              out_enable_n,
   input wire logic              cascade_serial_out,
   input wire spo_pkg::spo_par_t parallel_outputs
);
   import spo_pkg::*;
   logic [WIDTH-1:0] shadow;
   logic [3:0]       since_latch;
   logic             latch_q;
   always_ff @(posedge shift_clk or negedge shift_rst_n) begin
      if (!shift_rst_n) shadow <= '0;
      else shadow <= {shadow[WIDTH-2:0], serial_in};
   end
   // Saturating count of core cycles since a latch edge
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         latch_q <= 1'b0;
         since_latch <= 4'h0;
      end else begin
         latch_q <= latch_clk;
         if (latch_clk && !latch_q) since_latch <= 4'h0;
         else if (since_latch != 4'hf) since_latch <= since_latch + 4'h1;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   a_cascade_stage_h: assert property (cascade_serial_out == shadow[WIDTH-1])
      else $error("cascade differs from stage H");
   a_reset_clears_cascade: assert property (!shift_rst_n |-> !cascade_serial_out)
      else $error("cascade not cleared by reset");
   a_latch_copies: assert property ($rose(latch_clk) |-> ##14 parallel_outputs.data == shadow)
      else $error("latch did not copy stages");
   a_latch_holds: assert property (since_latch == 4'hf |-> $stable(parallel_outputs.data))
      else $error("latch changed without edge");
   a_reset_keeps_latch: assert property ($fell(shift_rst_n) |=> $stable(parallel_outputs) [*8])
      else $error("reset disturbed outputs");
   a_oe_turns_on: assert property ($fell(out_enable_n) |-> ##[1:4] parallel_outputs.oe == 8'hff)
      else $error("outputs not enabled");
   a_oe_turns_off: assert property ($rose(out_enable_n) |-> ##[1:4] parallel_outputs.oe == 8'h00)
      else $error("outputs not floated");
   a_oe_all_same: assert property (parallel_outputs.oe == 8'h00 || parallel_outputs.oe == 8'hff)
      else $error("enable bits differ");
   c_latch: cover property ($rose(latch_clk));
   c_float: cover property ($rose(out_enable_n));
   c_reset: cover property ($fell(shift_rst_n));
endmodule
bind spo_top spo_checker #(.WIDTH(WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) i_spo_checker (
   .core_clk(core_clk), .nrst(nrst), .shift_clk(shift_clk), .shift_rst_n(shift_rst_n),
   .serial_in(serial_in), .latch_clk(latch_clk), .out_enable_n(out_enable_n),
   .cascade_serial_out(cascade_serial_out), .parallel_outputs(parallel_outputs));

// File: verification/tb_spo_top.sv
/* Self-checking bench for the serial-in parallel-out latch.
   Assumes the controller model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module tb_spo_top;
   import spo_pkg::*;
   logic     core_clk     = 1'b0;
   logic     nrst         = 1'b0;
   // Reset pin low at start so the shift chain is known before the first shift
   logic     shift_rst_n  = 1'b0;
   logic     out_enable_n = 1'b0;
   logic     shift_clk, serial_in, latch_clk, cascade_serial_out;
   spo_par_t parallel_outputs;
   int       err_count    = 0;
   int       checks       = 0;
   always #2 core_clk = ~core_clk;
   spo_ctrl_model i_spo_ctrl_model (.shift_clk(shift_clk), .serial_in(serial_in),
      .latch_clk(latch_clk));
   spo_top i_spo_top (.core_clk(core_clk), .nrst(nrst), .shift_clk(shift_clk),
      .shift_rst_n(shift_rst_n), .serial_in(serial_in), .latch_clk(latch_clk),
      .out_enable_n(out_enable_n), .cascade_serial_out(cascade_serial_out),
      .parallel_outputs(parallel_outputs));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Twenty idle cycles let the crossing settle before anything is judged
   task automatic load(input logic [7:0] b);
      i_spo_ctrl_model.send_byte(b);
      wait_cyc(20);
   endtask
   task automatic latch;
      i_spo_ctrl_model.pulse_latch();
      wait_cyc(20);
   endtask
   task automatic t_shift_latch;
      load(8'ha5);
      check({7'h00, cascade_serial_out}, 8'h01);
      latch();
      check(parallel_outputs.data, 8'ha5);
   endtask
   task automatic t_hold;
      load(8'h5a);
      check(parallel_outputs.data, 8'ha5);
      wait_cyc(10);
      check({7'h00, cascade_serial_out}, 8'h00);
      latch();
      check(parallel_outputs.data, 8'h5a);
   endtask
   task automatic t_enable;
      out_enable_n <= 1'b1;
      wait_cyc(6);
      check(parallel_outputs.oe, 8'h00);
      out_enable_n <= 1'b0;
      wait_cyc(6);
      check(parallel_outputs.oe, 8'hff);
      check(parallel_outputs.data, 8'h5a);
   endtask
   task automatic t_reset;
      load(8'hc3);
      shift_rst_n <= 1'b0;
      wait_cyc(8);
      check({7'h00, cascade_serial_out}, 8'h00);
      check(parallel_outputs.data, 8'h5a);
      shift_rst_n <= 1'b1;
      wait_cyc(8);
      latch();
      check(parallel_outputs.data, 8'h00);
   endtask
   initial begin
      wait_cyc(4);
      nrst <= 1'b1;
      shift_rst_n <= 1'b1;
      wait_cyc(8);
      t_shift_latch();
      t_hold();
      t_enable();
      t_reset();
      give_verdict();
   end
   initial begin
      #20000;
      err_count++;
      give_verdict();
   end
endmodule
